// file: rtl/sdd_top.sv
// Diagnostic display logic of a servo drive front panel
// Contract
// - Not-ready while initializing, alarm, or servo-on off
// - Ready code once initialized and operable
// - Upper segments inputs, lower segments outputs
// - Pin functions come from assignment group
// - Forced outputs leave drive state untouched
// - Forcing only allowed with servo off
// - Jog only without external command
// - Positioning from PC only, no command
// - Inertia estimation from PC only
// - Calibration measures zero-volt residual level
// - Offset written automatically on completion
// - Two read-only firmware number screens
// - Mode steps modes, up/down select items
`timescale 1ns/1ns
`default_nettype none
module sdd_top
(
    input wire logic clock,
    input wire logic rstn,
    // Drive status
    input wire logic init_busy,
    input wire logic alarm_active,
    input wire logic ext_cmd_present,
    // Pins and normal drive logic
    input wire logic [sdd_pkg::DI_W-1:0] digital_input,
    input wire logic [sdd_pkg::DI_W*sdd_pkg::FN_W-1:0] io_assignment_param_group,
    input wire logic [sdd_pkg::DO_W-1:0] do_normal,
    input wire logic [sdd_pkg::AN_W-1:0] analog_speed_in,
    // Panel keys, one-cycle pulses
    input wire logic key_mode,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_set,
    // PC link commands, one-cycle pulses
    input wire logic pc_force_req,
    input wire logic pc_jog_req,
    input wire logic pc_pos_req,
    input wire logic pc_inertia_req,
    input wire logic pc_exit,
    input wire logic [sdd_pkg::DO_W-1:0] force_value,
    // Outputs
    output logic [sdd_pkg::DO_W-1:0] digital_output,
    output logic [7:0] not_ready_code,
    output logic [sdd_pkg::DI_W-1:0] seg_upper,
    output logic [sdd_pkg::DO_W-1:0] seg_lower,
    output logic [15:0] firmware_version_screen,
    output logic [1:0] disp_mode,
    output logic [sdd_pkg::SEL_W-1:0] diag_item,
    output logic force_active,
    output logic jog_active,
    output logic pos_active,
    output logic inertia_active,
    output logic cal_busy,
    output logic [sdd_pkg::AN_W-1:0] analog_offset_param
);
    import sdd_pkg::*;

    logic rst_s1_r, rst_s2_r;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire rst_n = rst_s2_r;

    // Pin synchronisers
    logic [DI_W-1:0] di_s1_r, di_s2_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            di_s1_r <= '0;
            di_s2_r <= '0;
        end
        else
        begin
            di_s1_r <= digital_input;
            di_s2_r <= di_s1_r;
        end
    end

    sdd_map_if mif ();
    assign mif.pin_level = di_s2_r;
    assign mif.pin_func = io_assignment_param_group;
    sdd_pin_map u_map (.m(mif));
    wire servo_on = mif.servo_on;

    sdd_state_e st_r, st_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [SEL_W-1:0] item_r, item_nxt;
    logic cal_pick_r, cal_pick_nxt;
    logic [4:0] cal_cnt_r, cal_cnt_nxt;
    logic [AN_W+CAL_SHIFT-1:0] cal_acc_r, cal_acc_nxt;
    logic [AN_W-1:0] offset_r, offset_nxt;
    logic [DO_W-1:0] dout_nxt;
    logic [7:0] code_nxt;
    logic [15:0] fw_nxt;
    logic cal_done;

    always_comb
    begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        item_nxt = item_r;
        cal_pick_nxt = cal_pick_r;
        cal_cnt_nxt = cal_cnt_r;
        cal_acc_nxt = cal_acc_r;
        offset_nxt = offset_r;
        cal_done = 1'b0;
        // Mode key cycles modes, up/down walk items in diagnostics
        if (st_r == SDD_ST_IDLE)
        begin
            if (key_mode)
            begin
                mode_nxt = (mode_r == MODE_LAST) ? 2'h0 : mode_r + 2'h1;
            end
            else if (mode_r == MODE_DIAG && key_up)
            begin
                item_nxt = (item_r == ITEM_LAST) ? ITEM_CTRL : item_r + 3'h1;
                cal_pick_nxt = 1'b0;
            end
            else if (mode_r == MODE_DIAG && key_down)
            begin
                item_nxt = (item_r == ITEM_CTRL) ? ITEM_LAST : item_r - 3'h1;
                cal_pick_nxt = 1'b0;
            end
        end
        case (st_r)
            SDD_ST_IDLE:
            begin
                if (pc_force_req && !servo_on)
                begin
                    st_nxt = SDD_ST_FORCE;
                end
                else if (pc_jog_req && !ext_cmd_present)
                begin
                    st_nxt = SDD_ST_JOG;
                end
                else if (pc_pos_req && !ext_cmd_present)
                begin
                    st_nxt = SDD_ST_POS;
                end
                else if (pc_inertia_req && !ext_cmd_present)
                begin
                    st_nxt = SDD_ST_INERTIA;
                end
                else if (mode_r == MODE_DIAG && !key_mode && key_set)
                begin
                    if (item_r == ITEM_FORCE && !servo_on)
                    begin
                        st_nxt = SDD_ST_FORCE;
                    end
                    else if (item_r == ITEM_JOG && !ext_cmd_present)
                    begin
                        st_nxt = SDD_ST_JOG;
                    end
                    else if (item_r == ITEM_OFFSET)
                    begin
                        st_nxt = SDD_ST_CAL_ARM;
                        cal_pick_nxt = 1'b0;
                    end
                    else if (item_r == ITEM_VERSION)
                    begin
                        // Set flips between version and system number screens
                        cal_pick_nxt = ~cal_pick_r;
                    end
                end
            end
            SDD_ST_FORCE:
            begin
                if (pc_exit || key_mode || servo_on)
                begin
                    st_nxt = SDD_ST_IDLE;
                end
            end
            SDD_ST_JOG, SDD_ST_POS, SDD_ST_INERTIA:
            begin
                if (pc_exit || key_mode || ext_cmd_present)
                begin
                    st_nxt = SDD_ST_IDLE;
                end
            end
            SDD_ST_CAL_ARM:
            begin
                if (key_up || key_down)
                begin
                    cal_pick_nxt = ~cal_pick_r;
                end
                else if (key_set && cal_pick_r)
                begin
                    st_nxt = SDD_ST_CAL_RUN;
                    cal_cnt_nxt = 5'h00;
                    cal_acc_nxt = '0;
                end
                else if (key_set || key_mode)
                begin
                    st_nxt = SDD_ST_IDLE;
                    cal_pick_nxt = 1'b0;
                end
            end
            SDD_ST_CAL_RUN:
            begin
                // Average samples of the idle input as the zero reference
                cal_acc_nxt = cal_acc_r + {{CAL_SHIFT{1'b0}}, analog_speed_in};
                cal_cnt_nxt = cal_cnt_r + 5'h01;
                if (cal_cnt_r == CAL_CNT_MAX)
                begin
                    cal_done = 1'b1;
                    offset_nxt = cal_acc_nxt[AN_W+CAL_SHIFT-1:CAL_SHIFT];
                    cal_pick_nxt = 1'b0;
                    st_nxt = SDD_ST_IDLE;
                end
            end
            default:
            begin
                st_nxt = SDD_ST_IDLE;
            end
        endcase
        // Forcing touches only the pins, never status or state
        dout_nxt = (st_nxt == SDD_ST_FORCE) ? force_value : do_normal;
        code_nxt = (init_busy || alarm_active || !servo_on) ? CODE_NOT_READY
                                                            : CODE_READY;
        fw_nxt = (item_nxt == ITEM_VERSION && cal_pick_nxt) ? FW_SYSTEM
                                                           : FW_VERSION;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= SDD_ST_IDLE;
            mode_r <= 2'h0;
            item_r <= ITEM_CTRL;
            cal_pick_r <= 1'b0;
            cal_cnt_r <= 5'h00;
            cal_acc_r <= '0;
            offset_r <= OFFSET_RST;
            digital_output <= '0;
            not_ready_code <= CODE_NOT_READY;
            seg_upper <= '0;
            seg_lower <= '0;
            firmware_version_screen <= FW_VERSION;
            disp_mode <= 2'h0;
            diag_item <= ITEM_CTRL;
            force_active <= 1'b0;
            jog_active <= 1'b0;
            pos_active <= 1'b0;
            inertia_active <= 1'b0;
            cal_busy <= 1'b0;
            analog_offset_param <= OFFSET_RST;
        end
        else
        begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            item_r <= item_nxt;
            cal_pick_r <= cal_pick_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            cal_acc_r <= cal_acc_nxt;
            offset_r <= offset_nxt;
            digital_output <= dout_nxt;
            not_ready_code <= code_nxt;
            seg_upper <= di_s2_r;
            seg_lower <= dout_nxt;
            firmware_version_screen <= fw_nxt;
            disp_mode <= mode_nxt;
            diag_item <= item_nxt;
            force_active <= (st_nxt == SDD_ST_FORCE);
            jog_active <= (st_nxt == SDD_ST_JOG);
            pos_active <= (st_nxt == SDD_ST_POS);
            inertia_active <= (st_nxt == SDD_ST_INERTIA);
            cal_busy <= (st_nxt == SDD_ST_CAL_RUN);
            analog_offset_param <= offset_nxt;
        end
    end

    sequence s_cal_armed;
        st_r == SDD_ST_CAL_ARM && key_set && cal_pick_r && !key_up && !key_down;
    endsequence
    sequence s_cal_result;
        ##1 cal_busy ##15 cal_done
        ##1 (!cal_busy && analog_offset_param == cal_acc_r[AN_W+CAL_SHIFT-1:CAL_SHIFT]);
    endsequence

    a_ready_code: assert property (@(posedge clock) disable iff (!rst_n)
        (init_busy || alarm_active || !servo_on) |=> not_ready_code == CODE_NOT_READY)
        else $error("Ready shown while drive not ready");
    a_ready_on: assert property (@(posedge clock) disable iff (!rst_n)
        (!init_busy && !alarm_active && servo_on) |=> not_ready_code == CODE_READY)
        else $error("Ready code missing");
    a_seg_upper: assert property (@(posedge clock) disable iff (!rst_n)
        seg_upper == $past(di_s2_r))
        else $error("Upper segments do not follow inputs");
    a_seg_lower: assert property (@(posedge clock) disable iff (!rst_n)
        seg_lower == digital_output)
        else $error("Lower segments do not follow outputs");
    a_force_servo_off: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(force_active)) |-> !$past(servo_on))
        else $error("Forcing entered with servo on");
    a_force_value: assert property (@(posedge clock) disable iff (!rst_n)
        force_active |-> digital_output == $past(force_value))
        else $error("Forced output value wrong");
    a_force_exit: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(force_active) |-> digital_output == $past(do_normal))
        else $error("Outputs not restored after forcing");
    a_jog_nocmd: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(jog_active) |-> !$past(ext_cmd_present))
        else $error("Jog started with external command");
    a_pos_pc: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(pos_active) |-> $past(pc_pos_req) && !$past(ext_cmd_present))
        else $error("Positioning started without PC request");
    a_inertia_pc: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(inertia_active) |-> $past(pc_inertia_req))
        else $error("Inertia test started from panel");
    a_cal_store: assert property (@(posedge clock) disable iff (!rst_n)
        s_cal_armed |-> s_cal_result)
        else $error("Offset not stored after calibration");
endmodule
`default_nettype wire

// file: rtl/sdd_pkg.sv
// Package of constants and types for the servo diagnostic display block
package sdd_pkg;
    localparam int DI_W = 10;
    localparam int DO_W = 6;
    localparam int FN_W = 4;
    localparam int AN_W = 12;
    localparam int SEL_W = 3;
    localparam int CAL_SHIFT = 4;
    localparam int CAL_SAMPLES = 16;
    localparam logic [4:0] CAL_CNT_MAX = 5'h0F;
    localparam logic [AN_W-1:0] OFFSET_RST = 12'h000;
    localparam logic [FN_W-1:0] FN_SERVO_ON = 4'h2;
    localparam logic [7:0] CODE_NOT_READY = 8'h0F;
    localparam logic [7:0] CODE_READY = 8'h01;
    localparam logic [15:0] FW_VERSION = 16'h0100;
    localparam logic [15:0] FW_SYSTEM = 16'h0001;
    localparam logic [SEL_W-1:0] ITEM_CTRL = 3'h0;
    localparam logic [SEL_W-1:0] ITEM_IO = 3'h1;
    localparam logic [SEL_W-1:0] ITEM_FORCE = 3'h2;
    localparam logic [SEL_W-1:0] ITEM_JOG = 3'h3;
    localparam logic [SEL_W-1:0] ITEM_POS = 3'h4;
    localparam logic [SEL_W-1:0] ITEM_INERTIA = 3'h5;
    localparam logic [SEL_W-1:0] ITEM_OFFSET = 3'h6;
    localparam logic [SEL_W-1:0] ITEM_VERSION = 3'h7;
    localparam logic [SEL_W-1:0] ITEM_LAST = 3'h7;
    localparam logic [1:0] MODE_LAST = 2'h3;
    localparam logic [1:0] MODE_DIAG = 2'h2;
    typedef enum logic [2:0] {
        SDD_ST_IDLE,
        SDD_ST_FORCE,
        SDD_ST_JOG,
        SDD_ST_POS,
        SDD_ST_INERTIA,
        SDD_ST_CAL_ARM,
        SDD_ST_CAL_RUN
    } sdd_state_e;
endpackage

// file: rtl/sdd_map_if.sv
// Interface carrying pin function assignment between the top and the mapper
`timescale 1ns/1ns
`default_nettype none
interface sdd_map_if;
    import sdd_pkg::*;
    logic [DI_W-1:0] pin_level;
    logic [DI_W*FN_W-1:0] pin_func;
    logic servo_on;
    modport host (output pin_level, output pin_func, input servo_on);
    modport mapper (input pin_level, input pin_func, output servo_on);
endinterface
`default_nettype wire

// file: rtl/sdd_pin_map.sv
// Maps digital input pins to drive functions using the assignment group
`timescale 1ns/1ns
`default_nettype none
module sdd_pin_map
(
    sdd_map_if.mapper m
);
    import sdd_pkg::*;

    function automatic logic any_pin_is(input logic [DI_W-1:0] lvl,
                                        input logic [DI_W*FN_W-1:0] fn,
                                        input logic [FN_W-1:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_W; i++)
        begin
            if (fn[i*FN_W +: FN_W] == code && lvl[i])
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Servo-on follows whichever pin is programmed for it
    assign m.servo_on = any_pin_is(m.pin_level, m.pin_func, FN_SERVO_ON);
endmodule
`default_nettype wire

// file: verif/sdd_panel_model.sv
// Model of the operator keypad and PC link issuing one-cycle requests
`timescale 1ns/1ns
`default_nettype none
module sdd_panel_model
(
    // Clock of the panel logic
    input wire logic clock,
    // Pulses: mode, up, down, set, force, jog, pos, inertia, exit
    output logic [8:0] pulse_bus
);
    initial pulse_bus = 9'h000;

    // One request held over exactly one rising edge, after a gap
    task automatic press(input int k, input int gap);
        repeat (gap) @(negedge clock);
        @(negedge clock);
        pulse_bus[k] = 1'b1;
        @(negedge clock);
        pulse_bus[k] = 1'b0;
    endtask

    // Operator arming of calibration: set, pick 1, set
    task automatic arm_cal();
        press(3, 0);
        press(1, 2);
        press(3, 3);
    endtask
endmodule
`default_nettype wire

// file: verif/sdd_top_bench.sv
// Self-checking bench for the diagnostic display block
`timescale 1ns/1ns
`default_nettype none
module sdd_top_bench;
    import sdd_pkg::*;
    localparam int K_MODE = 0;
    localparam int K_UP = 1;
    localparam int K_DOWN = 2;
    localparam int K_SET = 3;
    localparam int K_FORCE = 4;
    localparam int K_JOG = 5;
    localparam int K_EXIT = 8;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic init_busy = 1'b1;
    logic alarm_active = 1'b0;
    logic ext_cmd = 1'b0;
    logic [DI_W-1:0] din = 10'h000;
    logic [DI_W*FN_W-1:0] fmap = 40'h0000000002;
    logic [DO_W-1:0] do_norm = 6'h15;
    logic [DO_W-1:0] fval = 6'h2A;
    logic [AN_W-1:0] ain = 12'h035;
    logic [8:0] pulse_bus;
    logic [DO_W-1:0] dout;
    logic [DO_W-1:0] segl;
    logic [7:0] code;
    logic [DI_W-1:0] segu;
    logic [15:0] fw;
    logic [1:0] dmode;
    logic [SEL_W-1:0] item;
    logic f_act, j_act, p_act, i_act, cbusy;
    logic [AN_W-1:0] offs;
    int failures = 0;
    int n_compared = 0;

    always #4 clock = ~clock;

    sdd_panel_model i_sdd_panel_model (.clock(clock), .pulse_bus(pulse_bus));

    sdd_top i_sdd_top (
        .clock(clock), .rstn(rstn), .init_busy(init_busy), .alarm_active(alarm_active),
        .ext_cmd_present(ext_cmd), .digital_input(din), .io_assignment_param_group(fmap),
        .do_normal(do_norm), .analog_speed_in(ain), .key_mode(pulse_bus[0]),
        .key_up(pulse_bus[1]), .key_down(pulse_bus[2]), .key_set(pulse_bus[3]),
        .pc_force_req(pulse_bus[4]), .pc_jog_req(pulse_bus[5]), .pc_pos_req(pulse_bus[6]),
        .pc_inertia_req(pulse_bus[7]), .pc_exit(pulse_bus[8]), .force_value(fval),
        .digital_output(dout), .not_ready_code(code), .seg_upper(segu), .seg_lower(segl),
        .firmware_version_screen(fw), .disp_mode(dmode), .diag_item(item),
        .force_active(f_act), .jog_active(j_act), .pos_active(p_act),
        .inertia_active(i_act), .cal_busy(cbusy), .analog_offset_param(offs));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic p(input int k);
        i_sdd_panel_model.press(k, 0);
    endtask

    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic t_status();
        init_busy = 1'b0;
        din = 10'h001;
        idle(6);
        chk(code, CODE_READY);
        alarm_active = 1'b1;
        idle(3);
        chk(code, CODE_NOT_READY);
        alarm_active = 1'b0;
        din = 10'h000;
        idle(6);
        chk(code, CODE_NOT_READY);
        din = 10'h001;
        init_busy = 1'b1;
        idle(6);
        chk(code, CODE_NOT_READY);
        init_busy = 1'b0;
        idle(3);
        chk(code, CODE_READY);
    endtask

    task automatic t_io();
        din = 10'h2A5;
        idle(6);
        chk(segu, 16'h02A5);
        chk(segl, do_norm);
        chk(dout, do_norm);
        fmap = 40'h0000002000;
        din = 10'h001;
        idle(6);
        chk(code, CODE_NOT_READY);
        din = 10'h008;
        idle(6);
        chk(code, CODE_READY);
        fmap = 40'h0000000002;
        din = 10'h001;
        idle(6);
    endtask

    task automatic t_nav();
        p(K_MODE);
        p(K_MODE);
        chk(dmode, MODE_DIAG);
        repeat (4) p(K_UP);
        chk(item, ITEM_POS);
        p(K_SET);
        chk(p_act, 1'b0);
        p(K_UP);
        p(K_SET);
        chk(i_act, 1'b0);
        p(K_DOWN);
        p(K_DOWN);
        chk(item, ITEM_JOG);
        p(K_SET);
        chk(j_act, 1'b1);
        p(K_EXIT);
        chk(j_act, 1'b0);
        repeat (4) p(K_UP);
        chk(item, ITEM_VERSION);
        idle(1);
        chk(fw, FW_VERSION);
        p(K_SET);
        chk(fw, FW_SYSTEM);
        p(K_SET);
        chk(fw, FW_VERSION);
        repeat (4) p(K_MODE);
        chk(dmode, MODE_DIAG);
        p(K_DOWN);
        chk(item, ITEM_OFFSET);
    endtask

    task automatic t_tests();
        for (int k = K_JOG; k < K_EXIT; k++)
        begin
            ext_cmd = 1'b1;
            idle(2);
            p(k);
            chk({i_act, p_act, j_act}, 3'h0);
            ext_cmd = 1'b0;
            idle(2);
            p(k);
            chk({i_act, p_act, j_act}, 3'h1 << (k - K_JOG));
            p(K_EXIT);
        end
    endtask

    task automatic t_force();
        p(K_FORCE);
        chk(f_act, 1'b0);
        din = 10'h000;
        idle(6);
        p(K_FORCE);
        chk(f_act, 1'b1);
        idle(1);
        chk(dout, fval);
        chk(segl, fval);
        chk(j_act, 1'b0);
        p(K_EXIT);
        idle(1);
        chk(dout, do_norm);
        repeat (4) p(K_DOWN);
        chk(item, ITEM_FORCE);
        p(K_SET);
        chk(f_act, 1'b1);
        p(K_MODE);
        chk(f_act, 1'b0);
        chk(dmode, MODE_DIAG);
        repeat (4) p(K_UP);
        p(K_FORCE);
        din = 10'h001;
        idle(6);
        chk(f_act, 1'b0);
        chk(dout, do_norm);
    endtask

    task automatic t_cal();
        int n;
        chk(offs, OFFSET_RST);
        i_sdd_panel_model.arm_cal();
        chk(cbusy, 1'b1);
        n = 0;
        while (cbusy === 1'b1 && n < 40)
        begin
            idle(1);
            n++;
        end
        if (n == 40)
        begin
            failures++;
        end
        chk(offs, 12'h035);
    endtask

    initial
    begin
        idle(1);
        chk(code, CODE_NOT_READY);
        chk(fw, FW_VERSION);
        chk(dout, 6'h00);
        idle(1);
        rstn = 1'b1;
        idle(4);
        t_status();
        t_io();
        t_nav();
        t_tests();
        t_force();
        t_cal();
        final_report();
    end
endmodule
`default_nettype wire
